// [design/pie_bank1.sv]
// Peripheral interrupt enable bank 1 with Wishbone register access
//
// Operation
// - Priority off: pass only with global gate
// - Bit 6 enables converter-done interrupt
// - Bit 5 enables serial receive interrupt
// - Bit 4 enables serial transmit interrupt
// - Bit 2 enables capture/compare interrupt
// - Bit 1 enables timer-two match interrupt
// - Bit 0 enables timer-one overflow interrupt
// - Bits 7,3 read zero; reset clears enables
// - Flags set regardless of any enable
// - Enable bits pair with same-position flags
`timescale 1ns/1ps
module pie_bank1 (
  input  wire logic        clk_i,          // System clock, 25 MHz
  input  wire logic        reset_i,        // Synchronous reset, active high
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Wishbone write enable
  input  wire logic [4:0]  wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,       // Wishbone write data
  output logic      [31:0] wb_dat_o,       // Wishbone read data
  output logic             wb_ack_o,       // Wishbone acknowledge
  input  wire logic [7:0]  src_event_i,    // Peripheral condition pulses, flag layout
  input  wire logic        rx_full_i,      // Serial receive buffer full level
  input  wire logic        tx_empty_i,     // Serial transmit buffer empty level
  output logic      [7:0]  periph_req_o,   // Per-source gated requests
  output logic             periph_irq_o,   // Combined request to the core
  output logic             irq_o           // Event interrupt, level
);

  // Register state
  logic [7:0]  enable_r, enable_nxt;
  logic [7:0]  flag_r, flag_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  stat_r, stat_nxt;
  logic [7:0]  mask_r, mask_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic        ack_r, ack_nxt;
  logic [7:0]  req_r, req_nxt;
  logic        preq_r, preq_nxt;
  logic        irq_r, irq_nxt;

  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wr_byte;
  logic [7:0]  cond;

  // Low byte write data; only lane 0 carries these 8-bit registers
  assign wr_byte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  // Single-cycle answer; ack high blocks taking a held request twice
  assign wr_fire = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
  assign rd_fire = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;

  // Raw conditions: pulses plus serial buffer levels
  always_comb
  begin
    cond = src_event_i & pie_pkg::IMPL_MASK;
    cond[pie_pkg::BIT_SERIAL_RX] = rx_full_i;
    cond[pie_pkg::BIT_SERIAL_TX] = tx_empty_i;
  end

  // Decodes a byte address match
  function automatic logic hit(input logic [4:0] adr, input logic [4:0] want);
    hit = (adr == want);
  endfunction

  // Next register values
  always_comb
  begin
    enable_nxt = enable_r;
    flag_nxt   = flag_r;
    ctrl_nxt   = ctrl_r;
    stat_nxt   = stat_r;
    mask_nxt   = mask_r;
    if (wr_fire && wb_sel_i[0])
    begin
      if (hit(wb_adr_i, {1'b0, pie_pkg::ADDR_ENABLE_1}))
        enable_nxt = wr_byte & pie_pkg::IMPL_MASK;
      if (hit(wb_adr_i, {1'b0, pie_pkg::ADDR_FLAG_1}))
        flag_nxt = flag_r & ~(wr_byte & pie_pkg::SW_CLR_MASK);
      if (hit(wb_adr_i, {1'b0, pie_pkg::ADDR_CTRL}))
        ctrl_nxt = wr_byte[1:0];
      if (hit(wb_adr_i, {1'b0, pie_pkg::ADDR_IRQ_STAT}))
        stat_nxt = stat_r & ~wr_byte;
      if (hit(wb_adr_i, pie_pkg::ADDR_MASK))
        mask_nxt = wr_byte & pie_pkg::IMPL_MASK;
    end
    // Set wins over a same-cycle clear; no enable is consulted here
    flag_nxt = flag_nxt | (cond & pie_pkg::SW_CLR_MASK);
    // Serial flags mirror their buffer state
    flag_nxt[pie_pkg::BIT_SERIAL_RX] = rx_full_i;
    flag_nxt[pie_pkg::BIT_SERIAL_TX] = tx_empty_i;
    stat_nxt = stat_nxt | (cond & ~flag_r & pie_pkg::IMPL_MASK);
  end

  // Gating toward the core
  always_comb
  begin
    // Same position pairing of flag and enable
    req_nxt = flag_r & enable_r & pie_pkg::IMPL_MASK;
    // Without priority mode the global gate must be on
    if (!ctrl_r[pie_pkg::CTRL_PRIO_BIT] && !ctrl_r[pie_pkg::CTRL_GATE_BIT])
      req_nxt = 8'h00;
    preq_nxt = |req_nxt;
    irq_nxt  = |(stat_r & mask_r);
  end

  // Bus answer and read mux
  always_comb
  begin
    ack_nxt  = rd_fire || wr_fire;
    rdat_nxt = pie_pkg::ZERO_WORD;
    if (rd_fire)
    begin
      unique case (wb_adr_i)
        {1'b0, pie_pkg::ADDR_ENABLE_1}: rdat_nxt[7:0] = enable_r & pie_pkg::IMPL_MASK;
        {1'b0, pie_pkg::ADDR_FLAG_1}:   rdat_nxt[7:0] = flag_r;
        {1'b0, pie_pkg::ADDR_CTRL}:     rdat_nxt[1:0] = ctrl_r;
        {1'b0, pie_pkg::ADDR_IRQ_STAT}: rdat_nxt[7:0] = stat_r;
        pie_pkg::ADDR_MASK:             rdat_nxt[7:0] = mask_r;
        default:                        rdat_nxt = pie_pkg::ZERO_WORD;
      endcase
    end
  end

  // Registers; reset clears every enable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      enable_r <= pie_pkg::ENABLE_RESET;
      flag_r   <= pie_pkg::FLAG_RESET;
      ctrl_r   <= pie_pkg::CTRL_RESET;
      stat_r   <= pie_pkg::FLAG_RESET;
      mask_r   <= pie_pkg::FLAG_RESET;
      rdat_r   <= pie_pkg::ZERO_WORD;
      ack_r    <= 1'b0;
      req_r    <= pie_pkg::FLAG_RESET;
      preq_r   <= 1'b0;
      irq_r    <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      flag_r   <= flag_nxt;
      ctrl_r   <= ctrl_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      rdat_r   <= rdat_nxt;
      ack_r    <= ack_nxt;
      req_r    <= req_nxt;
      preq_r   <= preq_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign wb_dat_o     = rdat_r;
  assign wb_ack_o     = ack_r;
  assign periph_req_o = req_r;
  assign periph_irq_o = preq_r;
  assign irq_o        = irq_r;

endmodule // pie_bank1

// [design/pie_pkg.sv]
// Register map, field positions and reset values for the peripheral interrupt enable bank
package pie_pkg;
  // Register byte addresses (32-bit aligned words)
  localparam logic [3:0] ADDR_ENABLE_1 = 4'h0;  // peripheral_irq_enable_1
  localparam logic [3:0] ADDR_FLAG_1   = 4'h4;  // Request flags, write one to clear
  localparam logic [3:0] ADDR_CTRL     = 4'h8;  // Global gate and priority mode
  localparam logic [3:0] ADDR_IRQ_STAT = 4'hC;  // Sticky event status, write one to clear
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;  // Unused alias guard
  localparam logic [4:0] ADDR_MASK     = 5'h10; // Event interrupt mask

  // Bit positions shared by enables and flags
  localparam int BIT_TIMER1_OVF   = 0;
  localparam int BIT_TIMER2_MATCH = 1;
  localparam int BIT_CAPCOMP      = 2;
  localparam int BIT_SERIAL_TX    = 4;
  localparam int BIT_SERIAL_RX    = 5;
  localparam int BIT_CONV_DONE    = 6;

  // Implemented bits; 7 and 3 read zero
  localparam logic [7:0] IMPL_MASK    = 8'h77;
  // Flags that software may clear; serial flags follow the serial port
  localparam logic [7:0] SW_CLR_MASK  = 8'h47;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET   = 8'h00;

  // Control register fields
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_PRIO_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : pie_pkg

// [dv/pie_bank1_asserts.sv]
// Bus and gating checks for the peripheral interrupt enable bank
`timescale 1ns/1ps
module pie_bank1_asserts (
  input  wire logic        clk_i,        // System clock
  input  wire logic        reset_i,      // Sync reset
  input  wire logic        wb_cyc_i,     // Bus cycle
  input  wire logic        wb_stb_i,     // Bus strobe
  input  wire logic [4:0]  wb_adr_i,     // Bus address
  input  wire logic [31:0] wb_dat_o,     // Read data
  input  wire logic        wb_ack_o,     // Acknowledge
  input  wire logic [7:0]  periph_req_o, // Gated requests
  input  wire logic        periph_irq_o  // Combined request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Taken request and idle bus; ack must follow only the former
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence idle_s; !(wb_cyc_i && wb_stb_i); endsequence
  ack_latency_a: assert property (take_s |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  idle_no_ack_a: assert property (idle_s |=> !wb_ack_o)
    else $error("ack without request");
  // Read data is zero outside ack so stale values never leak
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero when idle");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  reserved_bits_a: assert property (wb_ack_o && wb_adr_i == 5'h00 |->
    !wb_dat_o[7] && !wb_dat_o[3]) else $error("unimplemented enable bit read one");
  unmapped_zero_a: assert property (wb_ack_o && wb_adr_i > 5'h10 |-> !(|wb_dat_o))
    else $error("unmapped read not zero");
  irq_or_a: assert property (periph_irq_o == (|periph_req_o))
    else $error("combined request disagrees with vector");
  req_gap_a: assert property (!periph_req_o[7] && !periph_req_o[3])
    else $error("request on unimplemented position");
endmodule // pie_bank1_asserts
bind pie_bank1 pie_bank1_asserts chk_u (.*);

// [dv/pie_periph_model.sv]
// Peripheral condition and serial buffer level source model
`timescale 1ns/1ps
module pie_periph_model (
  input  wire logic       clk_i,       // System clock
  output logic      [7:0] src_event_o, // One-cycle condition pulses
  output logic            rx_full_o,   // Receive buffer full level
  output logic            tx_empty_o   // Transmit buffer empty level
);
  // Sources start quiet so reset sees no conditions
  initial {src_event_o, rx_full_o, tx_empty_o} = 10'h000;
  // A condition lasts one clock, like a peripheral strobe
  task fire(input logic [7:0] m);
    src_event_o <= m;
    @(posedge clk_i);
    src_event_o <= 8'h00;
  endtask
  // Buffer levels move just after an edge
  task levels(input logic r, input logic t);
    rx_full_o <= r;
    tx_empty_o <= t;
  endtask
endmodule // pie_periph_model

// [dv/test_pie_bank1.sv]
// Self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
module test_pie_bank1;
  logic        clk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0000_0000, q;
  wire  logic [31:0] rd;
  wire  logic [7:0]  req, ev;
  wire  logic        ack, pirq, irq, rxf, txe;
  int          n_mismatch = 0, n_compared = 0;
  pie_bank1 DUT (.clk_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .src_event_i(ev), .rx_full_i(rxf), .tx_empty_i(txe), .periph_req_o(req),
    .periph_irq_o(pirq), .irq_o(irq));
  pie_periph_model src (.clk_i, .src_event_o(ev), .rx_full_o(rxf), .tx_empty_o(txe));
  initial forever #20 clk_i = ~clk_i;
  // Run takes about 130 cycles; this guards a dead bus
  initial #100_000 begin n_mismatch++; stop_test; end
  task stop_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic single cycle; held until ack is sampled, then one idle cycle
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    cyc <= 1'b1; we <= w; adr <= a; wd <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // Event to interrupt output takes two edges; three gives margin
  task wt; repeat (3) @(posedge clk_i); endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 5'h00, 8'h00); chk(q, 32'h0000_0000);
    bus(1, 5'h00, 8'hff); bus(0, 5'h00, 8'h00); chk(q, 32'h0000_0077);
    src.fire(8'h47); wt; chk(req, 8'h00);
    bus(0, 5'h04, 8'h00); chk(q, 32'h0000_0047);
    src.levels(1'b1, 1'b1);
    bus(1, 5'h08, 8'h01); wt; chk(req, 8'h77); chk(pirq, 1'b1);
    // One enable at a time for bits 0 to 6, unimplemented bit 3 included
    for (int b = 0; b < 7; b++)
    begin
      bus(1, 5'h00, 8'h01 << b); wt; chk(req, (8'h01 << b) & 8'h77);
    end
    bus(1, 5'h08, 8'h02); wt; chk(req, 8'h40);
    bus(0, 5'h08, 8'h00); chk(q, 32'h0000_0002);
    bus(1, 5'h10, 8'h20); wt; chk(irq, 1'b1);
    bus(0, 5'h10, 8'h00); chk(q, 32'h0000_0020);
    bus(1, 5'h10, 8'h00); wt; chk(irq, 1'b0);
    bus(1, 5'h0C, 8'hff); bus(1, 5'h10, 8'hff); wt; chk(irq, 1'b0);
    bus(1, 5'h04, 8'h47); src.fire(8'h01); wt; chk(irq, 1'b1);
    bus(0, 5'h0C, 8'h00); chk(q, 32'h0000_0001);
    bus(0, 5'h14, 8'h00); chk(q, 32'h0000_0000);
    // Second reset mid-run must clear enables that are set
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk(req, 8'h00);
    bus(0, 5'h00, 8'h00); chk(q, 32'h0000_0000);
    stop_test;
  end
endmodule // test_pie_bank1
